/* hdl/peripheral_control_regs.sv */
// peripheral control register bank with scalers, timer a and interrupt gating
// Functional notes
// - shared 8-bit scaler, bypassed when disabled
// - scale code n divides by 2^(n+1)
// - infrared off: pin high, plain counter
// - infrared plus carrier: scaler follows low segments
// - pwm mode waveform from pulse timers
// - long pulse ignores high time
// - pin function bit routes infrared to pin7
// - pull-down bits, active low, bits 7:6 large
// - open-drain bits, zero means open drain
// - pull-up bits, active low, bits 7:6 large
// - watchdog enable bit readable and writable
// - external interrupt select masks pin0 path
// - adc and comparator interrupt enables
// - watchdog prescaler bypass when disabled
// - watchdog code n divides by 2^(n+1)
// - per-source interrupt mask register
// - global enable on and off commands
// - timer a 8-bit up counter, reset clears
// - timer a overflows after 256 minus load
// - flag read returns flags and mask
`include "periph_map.svh"
`timescale 1ns/1ps
`default_nettype none
module peripheral_control_regs #(
	parameter bit LARGE_PACKAGE = 1'b1 // pins 7 and 6 of port 5 exist
) (
	input wire logic sys_clk_in, // instruction cycle clock, 40 mhz
	input wire logic rst_n_in, // asynchronous reset, active low
	input wire periph_pkg::axi_req_t axi_req_in, // register bus request
	output periph_pkg::axi_rsp_t axi_rsp_out, // register bus answer
	input wire logic [7:0] flag_set_in, // one-cycle flag set pulses
	input wire logic adc_done_flag_in, // adc completion flag level
	input wire logic comparator_change_flag_in, // comparator change flag level
	input wire logic timer_a_run_in, // timer a count enable
	input wire logic carrier_low_in, // carrier low segment step
	input wire logic modulator_in, // waveform from modulator datapath
	input wire logic port6_pin7_data_in, // port data for pin 7
	input wire logic port6_pin7_dir_in, // port direction for pin 7, 1 = input
	input wire logic port6_pin0_in, // raw pin 0 level, asynchronous
	output periph_pkg::pad_ctrl_t pad_ctrl_out, // pad pull and drive controls
	output periph_pkg::ir_ctrl_t ir_ctrl_out, // modulator mode bits
	output logic timer_c_tick_out, // timer c count step
	output logic watchdog_enable_out, // watchdog running
	output logic watchdog_tick_out, // watchdog count step
	output logic port6_pin7_out, // pin 7 drive value
	output logic port6_pin7_oe_out, // pin 7 output enable
	output logic ext_int_n_out, // masked external interrupt level
	output logic port6_pin0_sync_out, // synchronised pin 0 for port reads
	output logic irq_out // interrupt request to the core
);
	import periph_pkg::*;

	// whole state of the bank
	typedef struct packed {
		logic [7:0] ir_scale; // ir and timer c scale control
		logic [7:0] pull_down; // pull-down disable bits
		logic [7:0] open_drain; // open-drain disable bits
		logic [7:0] pull_high; // pull-up disable bits
		logic [7:0] wdt_ctrl; // watchdog and extra enables
		logic [7:0] irq_mask; // per-source mask
		logic [7:0] timer_a; // timer a count
		logic [7:0] flags; // interrupt flags
		logic [7:0] c_scale; // timer c scaler count
		logic [7:0] w_scale; // watchdog prescaler count
		logic gie; // global interrupt enable
		logic c_tick; // timer c step
		logic w_tick; // watchdog step
		logic irq; // interrupt request
		logic p0_meta; // first sync stage
		logic p0_sync; // second sync stage
		logic ext_n; // masked interrupt level
		logic p7_out; // pin 7 value
		logic p7_oe; // pin 7 enable
		logic aw_got; // write address held
		logic [31:0] aw_addr; // held write address
		logic w_got; // write data held
		logic [7:0] w_data; // held write byte
		logic w_lane; // byte lane 0 strobe
		logic awready; // bus ready flops
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t state_reg; // registered state
	state_t state_next; // next state

	// mask of low bits for a divide code: code n gives 2^(n+1) steps
	function automatic logic [7:0] ratio_mask(input logic [2:0] code);
		ratio_mask = (`ONE_MASK << (code + 3'h1)) - `ONE_MASK;
		if (code == 3'h7)
		begin
			ratio_mask = 8'hff;
		end
	endfunction

	// map a byte address onto a register number, 4'hf when unmapped
	function automatic logic [3:0] reg_index(input logic [31:0] addr);
		reg_index = 4'hf;
		if (addr[31:8] == 24'h000000)
		begin
			case (addr[7:0])
				`IR_SCALE_OFS: reg_index = 4'h0;
				`PULL_DOWN_OFS: reg_index = 4'h1;
				`OPEN_DRAIN_OFS: reg_index = 4'h2;
				`PULL_HIGH_OFS: reg_index = 4'h3;
				`WDT_MASK_OFS: reg_index = 4'h4;
				`IRQ_MASK_OFS: reg_index = 4'h5;
				`TIMER_A_OFS: reg_index = 4'h6;
				`IRQ_FLAGS_OFS: reg_index = 4'h7;
				`GLOBAL_IRQ_OFS: reg_index = 4'h8;
				default: reg_index = 4'hf;
			endcase
		end
	endfunction

	// bits that exist on this package variant of port 5
	localparam logic [7:0] PORT5_MASK = LARGE_PACKAGE ? 8'hff : `BIG_PKG_MASK;

	// next-state logic
	always_comb
	begin
		logic [3:0] widx;
		logic [3:0] ridx;
		logic step;
		logic [7:0] wv;
		logic [7:0] rv;
		logic pending;
		widx = reg_index(state_reg.aw_addr);
		ridx = reg_index(axi_req_in.araddr);
		step = 1'b0;
		wv = state_reg.w_data;
		rv = 8'h00;
		pending = 1'b0;
		state_next = state_reg;

		// timer a counts up and overflows past 8'hff
		if (timer_a_run_in)
		begin
			state_next.timer_a = state_reg.timer_a + 8'h01;
		end

		// timer c scaler: step source depends on mode
		step = 1'b1;
		if (state_reg.ir_scale[`IR_EN_BIT] && state_reg.ir_scale[`CARRIER_BIT])
		begin
			step = carrier_low_in;
		end
		if (!state_reg.ir_scale[`SCALE_EN_BIT])
		begin
			state_next.c_tick = step;
		end
		else
		begin
			state_next.c_tick = step && ((state_reg.c_scale & ratio_mask(state_reg.ir_scale[`SCALE_SEL_HI:`SCALE_SEL_LO]))
				== ratio_mask(state_reg.ir_scale[`SCALE_SEL_HI:`SCALE_SEL_LO]));
			if (step)
			begin
				state_next.c_scale = state_reg.c_scale + 8'h01;
			end
		end

		// watchdog prescaler runs only while the watchdog is on
		if (!state_reg.wdt_ctrl[`WDT_EN_BIT])
		begin
			state_next.w_tick = 1'b0;
		end
		else if (!state_reg.wdt_ctrl[`WDT_PS_EN_BIT])
		begin
			state_next.w_tick = 1'b1;
		end
		else
		begin
			state_next.w_tick = (state_reg.w_scale & ratio_mask(state_reg.wdt_ctrl[`WDT_PS_HI:`WDT_PS_LO]))
				== ratio_mask(state_reg.wdt_ctrl[`WDT_PS_HI:`WDT_PS_LO]);
			state_next.w_scale = state_reg.w_scale + 8'h01;
		end

		// pin 0 synchroniser and masked interrupt path
		state_next.p0_meta = port6_pin0_in;
		state_next.p0_sync = state_reg.p0_meta;
		state_next.ext_n = state_reg.wdt_ctrl[`EXT_SEL_BIT] ? state_reg.p0_sync : 1'b1;

		// pin 7: infrared output or plain port pin
		if (state_reg.ir_scale[`PIN_FUNC_BIT])
		begin
			state_next.p7_out = state_reg.ir_scale[`IR_EN_BIT] ? modulator_in : 1'b1;
			state_next.p7_oe = 1'b1;
		end
		else
		begin
			state_next.p7_out = port6_pin7_data_in;
			state_next.p7_oe = !port6_pin7_dir_in;
		end

		// write address and data are taken independently
		if (axi_req_in.awvalid && state_reg.awready)
		begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = axi_req_in.awaddr;
		end
		if (axi_req_in.wvalid && state_reg.wready)
		begin
			state_next.w_got = 1'b1;
			state_next.w_data = axi_req_in.wdata[7:0];
			state_next.w_lane = axi_req_in.wstrb[0];
		end

		// software clear of flags comes before hardware set
		pending = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
		if (pending)
		begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = (widx == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
			if (state_reg.w_lane)
			begin
				case (widx)
					4'h0:
					begin
						state_next.ir_scale = wv;
						state_next.c_scale = 8'h00;
					end
					4'h1: state_next.pull_down = wv & PORT5_MASK;
					4'h2: state_next.open_drain = wv;
					4'h3: state_next.pull_high = wv & PORT5_MASK;
					4'h4:
					begin
						state_next.wdt_ctrl = wv;
						state_next.w_scale = 8'h00;
					end
					4'h5: state_next.irq_mask = wv;
					4'h6: state_next.timer_a = wv;
					4'h7: state_next.flags = state_reg.flags & ~wv;
					4'h8:
					begin
						if (wv[`GIE_OFF_BIT])
						begin
							state_next.gie = 1'b0;
						end
						else if (wv[`GIE_ON_BIT])
						begin
							state_next.gie = 1'b1;
						end
					end
					default:
					begin
						state_next.gie = state_reg.gie;
					end
				endcase
			end
		end
		if (state_reg.bvalid && axi_req_in.bready)
		begin
			state_next.bvalid = 1'b0;
		end

		// hardware sets win over a clear in the same cycle; the external flag is never set while external select is off
		state_next.flags = state_next.flags | flag_set_in;
		if (timer_a_run_in && state_reg.timer_a == 8'hff)
		begin
			state_next.flags[`TIMER_A_FLAG_BIT] = 1'b1;
		end
		if (!state_reg.wdt_ctrl[`EXT_SEL_BIT])
		begin
			state_next.flags[`EXT_FLAG_BIT] = state_reg.flags[`EXT_FLAG_BIT] && state_next.flags[`EXT_FLAG_BIT]
				&& !flag_set_in[`EXT_FLAG_BIT];
		end

		// read channel: one read under way at a time
		if (state_reg.rvalid && axi_req_in.rready)
		begin
			state_next.rvalid = 1'b0;
		end
		if (axi_req_in.arvalid && state_reg.arready)
		begin
			case (ridx)
				4'h0: rv = state_reg.ir_scale;
				4'h1: rv = state_reg.pull_down;
				4'h2: rv = state_reg.open_drain;
				4'h3: rv = state_reg.pull_high;
				4'h4: rv = state_reg.wdt_ctrl;
				4'h5: rv = state_reg.irq_mask;
				4'h6: rv = state_reg.timer_a;
				4'h7: rv = state_reg.flags & state_reg.irq_mask;
				4'h8: rv = {7'h00, state_reg.gie};
				default: rv = 8'h00;
			endcase
			state_next.rvalid = 1'b1;
			state_next.rdata = {24'h000000, rv};
			state_next.rresp = (ridx == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
		end

		// ready flops follow what is still held
		state_next.awready = !state_next.aw_got && !state_next.bvalid;
		state_next.wready = !state_next.w_got && !state_next.bvalid;
		state_next.arready = !state_next.rvalid;

		// request needs flag, mask and global enable
		state_next.irq = state_reg.gie && ((|(state_reg.flags & state_reg.irq_mask))
			|| (state_reg.wdt_ctrl[`ADC_IE_BIT] && adc_done_flag_in)
			|| (state_reg.wdt_ctrl[`CMP_IE_BIT] && comparator_change_flag_in));
	end

	// state register
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= '0;
			state_reg.pull_down <= `PAD_RESET;
			state_reg.open_drain <= `PAD_RESET;
			state_reg.pull_high <= `PAD_RESET;
			state_reg.ir_scale <= `CTRL_RESET;
			state_reg.timer_a <= `CTRL_RESET;
			state_reg.ext_n <= 1'b1;
			state_reg.p7_out <= 1'b1;
			state_reg.p0_meta <= 1'b1;
			state_reg.p0_sync <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state flops
	assign axi_rsp_out.awready = state_reg.awready;
	assign axi_rsp_out.wready = state_reg.wready;
	assign axi_rsp_out.bvalid = state_reg.bvalid;
	assign axi_rsp_out.bresp = state_reg.bresp;
	assign axi_rsp_out.arready = state_reg.arready;
	assign axi_rsp_out.rvalid = state_reg.rvalid;
	assign axi_rsp_out.rdata = state_reg.rdata;
	assign axi_rsp_out.rresp = state_reg.rresp;
	assign pad_ctrl_out.pulldown_disable_bits = state_reg.pull_down | ~PORT5_MASK;
	assign pad_ctrl_out.opendrain_disable_bits = state_reg.open_drain;
	assign pad_ctrl_out.pullup_disable_bits = state_reg.pull_high | ~PORT5_MASK;
	assign ir_ctrl_out.infrared_enable = state_reg.ir_scale[`IR_EN_BIT];
	assign ir_ctrl_out.carrier_mode_select = state_reg.ir_scale[`CARRIER_BIT];
	assign ir_ctrl_out.long_pulse_select = state_reg.ir_scale[`LONG_PULSE_BIT];
	assign ir_ctrl_out.infrared_pin_function = state_reg.ir_scale[`PIN_FUNC_BIT];
	assign timer_c_tick_out = state_reg.c_tick;
	assign watchdog_enable_out = state_reg.wdt_ctrl[`WDT_EN_BIT];
	assign watchdog_tick_out = state_reg.w_tick;
	assign port6_pin7_out = state_reg.p7_out;
	assign port6_pin7_oe_out = state_reg.p7_oe;
	assign ext_int_n_out = state_reg.ext_n;
	assign port6_pin0_sync_out = state_reg.p0_sync;
	assign irq_out = state_reg.irq;
endmodule
`default_nettype wire

/* include/periph_map.svh */
// register offsets, field positions and reset values of the peripheral control bank
`ifndef PERIPH_MAP_SVH
`define PERIPH_MAP_SVH
// byte offsets on the register bus
`define IR_SCALE_OFS 8'h00
`define PULL_DOWN_OFS 8'h04
`define OPEN_DRAIN_OFS 8'h08
`define PULL_HIGH_OFS 8'h0c
`define WDT_MASK_OFS 8'h10
`define IRQ_MASK_OFS 8'h14
`define TIMER_A_OFS 8'h18
`define IRQ_FLAGS_OFS 8'h1c
`define GLOBAL_IRQ_OFS 8'h20
// field positions in the ir and scale register
`define SCALE_EN_BIT 7
`define SCALE_SEL_HI 6
`define SCALE_SEL_LO 4
`define IR_EN_BIT 3
`define CARRIER_BIT 2
`define LONG_PULSE_BIT 1
`define PIN_FUNC_BIT 0
// field positions in the watchdog register
`define WDT_EN_BIT 7
`define EXT_SEL_BIT 6
`define ADC_IE_BIT 5
`define CMP_IE_BIT 4
`define WDT_PS_EN_BIT 3
`define WDT_PS_HI 2
`define WDT_PS_LO 0
// flag positions and global control bits
`define TIMER_A_FLAG_BIT 3
`define EXT_FLAG_BIT 2
`define GIE_ON_BIT 0
`define GIE_OFF_BIT 1
// reset values and masks
`define CTRL_RESET 8'h00
`define PAD_RESET 8'hff
`define ONE_MASK 8'h01
`define BIG_PKG_MASK 8'h3f
// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* include/periph_pkg.sv */
// types shared by the peripheral control bank and its users
package periph_pkg;
	// axi4-lite request from the master
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} axi_req_t;
	// axi4-lite answer from the slave
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;
	// pad controls, one bit per pin, active low enables
	typedef struct packed {
		logic [7:0] pulldown_disable_bits;
		logic [7:0] opendrain_disable_bits;
		logic [7:0] pullup_disable_bits;
	} pad_ctrl_t;
	// modulator mode bits for the modulator datapath
	typedef struct packed {
		logic infrared_enable;
		logic carrier_mode_select;
		logic long_pulse_select;
		logic infrared_pin_function;
	} ir_ctrl_t;
endpackage

/* test/peripheral_control_regs_props.sv */
// assertion checker bound to the peripheral control register bank
`timescale 1ns/1ps
`default_nettype none
module peripheral_control_regs_props (
	input wire logic sys_clk_in, // bank clock
	input wire logic rst_n_in, // async reset, active low
	input wire periph_pkg::axi_req_t axi_req_in, // bus request
	input wire periph_pkg::axi_rsp_t axi_rsp_out, // bus answer
	input wire periph_pkg::pad_ctrl_t pad_ctrl_out, // pad controls
	input wire periph_pkg::ir_ctrl_t ir_ctrl_out, // modulator mode bits
	input wire logic watchdog_enable_out, // watchdog running
	input wire logic watchdog_tick_out, // watchdog step
	input wire logic modulator_in, // modulator waveform
	input wire logic port6_pin7_data_in, // pin 7 port data
	input wire logic port6_pin7_dir_in, // pin 7 direction
	input wire logic port6_pin7_out, // pin 7 drive value
	input wire logic port6_pin7_oe_out, // pin 7 drive enable
	input wire logic port6_pin0_in, // raw pin 0 level
	input wire logic port6_pin0_sync_out // synchronised pin 0
);
	import periph_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// address and data taken at one edge
	sequence s_wr_taken;
		axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready;
	endsequence
	// read address taken
	sequence s_rd_taken;
		axi_req_in.arvalid && axi_rsp_out.arready;
	endsequence
	// write answer two cycles after the take
	property p_wr_lat;
		s_wr_taken |-> ##1 !axi_rsp_out.bvalid ##1 axi_rsp_out.bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	// read answer next cycle, upper bits zero
	property p_rd_lat;
		s_rd_taken |=> axi_rsp_out.rvalid && axi_rsp_out.rdata[31:8] == 24'h0;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late or wide");
	// write answer stands until taken
	property p_b_hold;
		axi_rsp_out.bvalid && !axi_req_in.bready |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	// read answer stands until taken
	property p_r_hold;
		axi_rsp_out.rvalid && !axi_req_in.rready |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	// control outputs change only with a write
	property p_cfg_write;
		!$stable({pad_ctrl_out, ir_ctrl_out, watchdog_enable_out}) |-> axi_rsp_out.bvalid && !$past(axi_rsp_out.bvalid);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("control changed without write");
	// watchdog steps only while enabled
	property p_wdt_tick;
		watchdog_tick_out |-> $past(watchdog_enable_out) || $past(watchdog_enable_out, 2);
	endproperty
	a_wdt_tick: assert property (p_wdt_tick) else $error("watchdog step while off");
	// pin 7 carries the infrared output, high when modulator off
	property p_pin7_ir;
		ir_ctrl_out.infrared_pin_function [*2] |-> port6_pin7_oe_out &&
			port6_pin7_out == ($past(ir_ctrl_out.infrared_enable) ? $past(modulator_in) : 1'b1);
	endproperty
	a_pin7_ir: assert property (p_pin7_ir) else $error("pin 7 infrared drive wrong");
	// pin 7 as plain port pin
	property p_pin7_io;
		!ir_ctrl_out.infrared_pin_function [*2] |->
			port6_pin7_out == $past(port6_pin7_data_in) && port6_pin7_oe_out == !$past(port6_pin7_dir_in);
	endproperty
	a_pin7_io: assert property (p_pin7_io) else $error("pin 7 port drive wrong");
	// pin 0 passes exactly two flops
	property p_pin0_sync;
		$past(rst_n_in, 2) |-> port6_pin0_sync_out == $past(port6_pin0_in, 2);
	endproperty
	a_pin0_sync: assert property (p_pin0_sync) else $error("pin 0 sync wrong");
endmodule
bind peripheral_control_regs peripheral_control_regs_props u_props (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .pad_ctrl_out(pad_ctrl_out), .ir_ctrl_out(ir_ctrl_out),
	.watchdog_enable_out(watchdog_enable_out), .watchdog_tick_out(watchdog_tick_out), .modulator_in(modulator_in),
	.port6_pin7_data_in(port6_pin7_data_in), .port6_pin7_dir_in(port6_pin7_dir_in),
	.port6_pin7_out(port6_pin7_out), .port6_pin7_oe_out(port6_pin7_oe_out), .port6_pin0_in(port6_pin0_in),
	.port6_pin0_sync_out(port6_pin0_sync_out));
`default_nettype wire

/* test/peripheral_control_regs_test.sv */
// self-checking bench for the peripheral control register bank
`timescale 1ns/1ps
`default_nettype none
`include "periph_map.svh"
module peripheral_control_regs_test;
	import periph_pkg::*;
	logic clk, rst_n, run, clow, mod, d7, dir7, p0, tc_tick, wen, wtick, p7, p7oe, exn, p0s, irq; // dut pins
	logic adc, cmp; // adc and comparator flag levels
	logic [2:0] ph; // pin 0 history, newest in bit 0
	logic [7:0] fset; // flag set pulses
	logic [1:0] r; // bus response
	logic [31:0] d, e; // data and expectation
	axi_req_t req; // bus request
	axi_rsp_t rsp; // bus answer
	pad_ctrl_t pad; // pad controls
	ir_ctrl_t irc; // mode bits
	integer miscompares, n_checks, seed, nw, nc, nh, k; // counters
	peripheral_control_regs u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .axi_req_in(req), .axi_rsp_out(rsp),
		.flag_set_in(fset), .adc_done_flag_in(adc), .comparator_change_flag_in(cmp), .timer_a_run_in(run),
		.carrier_low_in(clow), .modulator_in(mod), .port6_pin7_data_in(d7), .port6_pin7_dir_in(dir7),
		.port6_pin0_in(p0), .pad_ctrl_out(pad), .ir_ctrl_out(irc), .timer_c_tick_out(tc_tick),
		.watchdog_enable_out(wen), .watchdog_tick_out(wtick), .port6_pin7_out(p7), .port6_pin7_oe_out(p7oe),
		.ext_int_n_out(exn), .port6_pin0_sync_out(p0s), .irq_out(irq));
	// clock
	always #12.5 clk = ~clk;
	// random pin traffic
	always @(posedge clk)
		{mod, d7, dir7, p0} <= 4'($random(seed));
	// compare and count
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// verdict and stop
	task end_sim;
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bus write, address and data released as taken
	task automatic wr(input logic [7:0] a, input logic [31:0] dd);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		req.awaddr <= {24'h0, a};
		req.wdata <= dd;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge clk);
			aw = aw | rsp.awready;
			w = w | rsp.wready;
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end
		do @(posedge clk); while (!rsp.bvalid);
		r = rsp.bresp;
	endtask
	// bus read
	task automatic rd(input logic [7:0] a);
		req.araddr <= {24'h0, a};
		req.arvalid <= 1'b1;
		do @(posedge clk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
	endtask
	// watchdog span
	initial
	begin
		#500000;
		miscompares++;
		end_sim;
	end
	// main sequence
	initial
	begin
		seed = 55084;
		miscompares = 0;
		n_checks = 0;
		clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		req.wstrb = 4'hf;
		req.bready = 1'b1;
		req.rready = 1'b1;
		fset = 8'h00;
		{run, clow, adc, cmp} = 4'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// reset values of the seven registers from ir scale to timer a
		for (int i = 0; i < 7; i++)
		begin
			rd(8'(i * 4));
			check(d, (i >= 1 && i <= 3) ? 32'hff : 32'h0);
		end
		check(32'(irq), 32'h0);
		// random write and read back, side outputs follow
		repeat (4)
			for (int i = 0; i < 7; i++)
			begin
				d = $random(seed);
				e = {24'h0, d[7:0]};
				wr(8'(i * 4), d);
				check(32'(r), 32'(`RESP_OKAY));
				if (i == 0) check(32'(irc), e & 32'hf);
				if (i == 1) check(32'(pad.pulldown_disable_bits), e);
				if (i == 2) check(32'(pad.opendrain_disable_bits), e);
				if (i == 3) check(32'(pad.pullup_disable_bits), e);
				if (i == 4) check(32'(wen), 32'(e[7]));
				rd(8'(i * 4));
				check(d, e);
			end
		// unmapped place
		rd(8'h24);
		check({d, 30'h0, r}, {32'h0, 30'h0, `RESP_SLVERR});
		wr(8'h24, 32'h5a);
		check(32'(r), 32'(`RESP_SLVERR));
		// byte lane 0 off: write ignored but answered okay
		wr(`IRQ_MASK_OFS, 32'h5a);
		req.wstrb <= 4'he;
		wr(`IRQ_MASK_OFS, 32'h00);
		req.wstrb <= 4'hf;
		check(32'(r), 32'(`RESP_OKAY));
		rd(`IRQ_MASK_OFS);
		check(d, 32'h5a);
		// scaler rates, boundary codes and bypass
		for (k = 0; k < 5; k++)
		begin
			e = (k == 3) ? 7 : k;
			wr(`WDT_MASK_OFS, {24'h0, 1'b1, 3'h0, k < 4, e[2:0]});
			wr(`IR_SCALE_OFS, {24'h0, k < 4, e[2:0], 4'h0});
			nw = 0;
			nc = 0;
			repeat (512)
			begin
				@(posedge clk);
				nw += wtick;
				nc += tc_tick;
			end
			e = (k == 4) ? 512 : 512 >> (e + 1);
			check(32'(nw >= e - 1 && nw <= e + 1), 32'h1);
			check(32'(nc >= e - 1 && nc <= e + 1), 32'h1);
			check(32'(exn), 32'h1);
		end
		// external select on: pin 0 synchronised and passed through
		wr(`WDT_MASK_OFS, 32'h40);
		ph = 3'h0;
		for (k = 0; k < 12; k++)
		begin
			@(posedge clk);
			if (k >= 3) check({30'h0, exn, p0s}, {30'h0, ph[2], ph[1]});
			ph = {ph[1:0], p0};
		end
		// carrier mode: timer c follows the low segments
		wr(`IR_SCALE_OFS, 32'h0c);
		nc = 0;
		nh = 0;
		repeat (64)
		begin
			@(posedge clk);
			nh += clow;
			nc += tc_tick;
			clow <= 1'($random(seed));
		end
		clow <= 1'b0;
		repeat (3)
		begin
			@(posedge clk);
			nh += clow;
			nc += tc_tick;
		end
		check(32'(nc >= nh - 1 && nc <= nh + 1), 32'h1);
		// infrared routed to pin 7 with modulator off
		wr(`IR_SCALE_OFS, 32'h01);
		repeat (3) @(posedge clk);
		check({p7, p7oe}, 2'b11);
		// timer a overflow, masked flag read and request gating
		wr(`IRQ_MASK_OFS, 32'h08);
		e = 32'hf0 | 4'($random(seed));
		wr(`TIMER_A_OFS, e);
		fset <= 8'h80;
		run <= 1'b1;
		@(posedge clk);
		fset <= 8'h00;
		repeat (255 - e[7:0]) @(posedge clk);
		run <= 1'b0;
		rd(`TIMER_A_OFS);
		check(d, 32'h0);
		rd(`IRQ_FLAGS_OFS);
		check(d, 32'h08);
		check(32'(irq), 32'h0);
		wr(`GLOBAL_IRQ_OFS, 32'h01);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h1);
		wr(`IRQ_MASK_OFS, 32'h00);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0);
		wr(`IRQ_MASK_OFS, 32'h08);
		wr(`GLOBAL_IRQ_OFS, 32'h03);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0);
		wr(`IRQ_FLAGS_OFS, 32'hff);
		rd(`IRQ_FLAGS_OFS);
		check(d, 32'h0);
		// adc and comparator requests gated by their enables
		wr(`GLOBAL_IRQ_OFS, 32'h01);
		wr(`WDT_MASK_OFS, 32'h20);
		adc <= 1'b1;
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h1);
		adc <= 1'b0;
		cmp <= 1'b1;
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0);
		wr(`WDT_MASK_OFS, 32'h10);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h1);
		end_sim;
	end
endmodule
`default_nettype wire
